/* core/cpurf_pkg.sv */
// Package with shared constants and carriers for the processor register file.
package cpurf_pkg;

	// ------------------------------------------------------------------
	// Register widths
	// ------------------------------------------------------------------
	localparam int DATA_W = 16;
	localparam int ADDR_W = 24;
	localparam int FLAG_W = 16;

	// ------------------------------------------------------------------
	// Avalon word offsets (byte addresses, one aligned word each)
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_DATA_ZERO    = 8'h00;
	localparam logic [7:0] OFS_DATA_ONE     = 8'h04;
	localparam logic [7:0] OFS_DATA_TWO     = 8'h08;
	localparam logic [7:0] OFS_DATA_THREE   = 8'h0C;
	localparam logic [7:0] OFS_ADDR_ZERO    = 8'h10;
	localparam logic [7:0] OFS_ADDR_ONE     = 8'h14;
	localparam logic [7:0] OFS_STATIC_BASE  = 8'h18;
	localparam logic [7:0] OFS_FRAME_BASE   = 8'h1C;
	localparam logic [7:0] OFS_USER_SP      = 8'h20;
	localparam logic [7:0] OFS_INT_SP       = 8'h24;
	localparam logic [7:0] OFS_VECTOR_BASE  = 8'h28;
	localparam logic [7:0] OFS_NEXT_IP      = 8'h2C;
	localparam logic [7:0] OFS_FLAG_WORD    = 8'h30;
	localparam logic [7:0] OFS_LONG_LOW     = 8'h34;
	localparam logic [7:0] OFS_LONG_HIGH    = 8'h38;
	localparam logic [7:0] OFS_ACTIVE_SP    = 8'h3C;
	localparam logic [7:0] OFS_EVENT        = 8'h40;
	localparam logic [7:0] OFS_ALU_RESULT   = 8'h44;
	localparam logic [7:0] OFS_PROBE_ADDR   = 8'h48;
	localparam logic [7:0] OFS_REGION       = 8'h4C;

	// ------------------------------------------------------------------
	// Flag word bit positions
	// ------------------------------------------------------------------
	localparam int FLG_CARRY    = 0;
	localparam int FLG_DEBUG    = 1;
	localparam int FLG_ZERO     = 2;
	localparam int FLG_SIGN     = 3;
	localparam int FLG_BANK     = 4;
	localparam int FLG_OVERFLOW = 5;
	localparam int FLG_INT_EN   = 6;
	localparam int FLG_STACK    = 7;
	localparam int FLG_IPL_LO   = 12;
	localparam int FLG_IPL_HI   = 14;
	localparam logic [15:0] FLG_IMPL_MASK = 16'h70FF;
	localparam logic [15:0] FLG_RESET     = 16'h0000;

	// ------------------------------------------------------------------
	// Event register fields
	// ------------------------------------------------------------------
	localparam int EVT_HW_INT   = 0;
	localparam int EVT_SW_INT   = 1;
	localparam int EVT_LVL_LO   = 8;
	localparam int EVT_LVL_HI   = 10;
	localparam int EVT_NUM_LO   = 16;
	localparam int EVT_NUM_HI   = 21;
	localparam int EVT_ACCEPT   = 0;
	localparam logic [5:0] SW_INT_STACK_MAX = 6'h1F;

	// Alu result register fields.
	localparam int ALU_CARRY  = 16;
	localparam int ALU_OVF    = 17;
	localparam int ALU_UPDATE = 18;
	localparam int ALU_WIDE   = 19;

	// ------------------------------------------------------------------
	// Memory map
	// ------------------------------------------------------------------
	localparam logic [23:0] SFR_FIRST     = 24'h000000;
	localparam logic [23:0] SFR_LAST      = 24'h0003FF;
	localparam logic [23:0] RAM_FIRST     = 24'h000400;
	localparam logic [23:0] SPAGE_FIRST   = 24'hFFFE00;
	localparam logic [23:0] SPAGE_LAST    = 24'hFFFFDB;
	localparam logic [23:0] FIXVEC_FIRST  = 24'hFFFFDC;
	localparam logic [23:0] RAM_SIZE_DEF  = 24'h008000;
	localparam logic [23:0] ROM_SIZE_DEF  = 24'h040000;

	// Region codes returned by the address decoder.
	typedef enum logic [2:0] {
		CPURF_REG_SFR,
		CPURF_REG_RAM,
		CPURF_REG_EXT,
		CPURF_REG_ROM,
		CPURF_REG_SPAGE,
		CPURF_REG_FIXVEC
	} cpurf_region_t;

	// Decoder answer carried as one group.
	typedef struct packed {
		cpurf_region_t region;
		logic          reserved;
	} cpurf_decode_t;

	// One bank of eight banked registers.
	typedef struct packed {
		logic [15:0] data_reg_zero;
		logic [15:0] data_reg_one;
		logic [15:0] data_reg_two;
		logic [15:0] data_reg_three;
		logic [23:0] addr_pointer_zero;
		logic [23:0] addr_pointer_one;
		logic [23:0] static_base;
		logic [23:0] frame_base;
	} cpurf_bank_t;

	// Flag result from the flag evaluator.
	typedef struct packed {
		logic carry;
		logic zero;
		logic sign;
		logic overflow;
	} cpurf_arith_t;

endpackage

/* core/cpurf_flag_eval.sv */
// Flag evaluator that derives zero and sign from an arithmetic result.
`timescale 1ns/1ps
module cpurf_flag_eval (
	input  wire logic [31:0]          result,
	input  wire logic                 wide,
	input  wire logic                 carry_in,
	input  wire logic                 ovf_in,
	output cpurf_pkg::cpurf_arith_t   flags
);
	// ------------------------------------------------------------------
	// Evaluation
	// ------------------------------------------------------------------
	// Narrow results look only at the low word so stale upper bits
	// never disturb a 16-bit operation.
	always_comb
	begin
		flags.carry    = carry_in;
		flags.overflow = ovf_in;
		if (wide)
		begin
			flags.zero = (result == 32'h00000000);
			flags.sign = result[31];
		end
		else
		begin
			flags.zero = (result[15:0] == 16'h0000);
			flags.sign = result[15];
		end
	end
endmodule

/* core/cpurf_addr_decode.sv */
// Address decoder for the 16-Mbyte linear memory map.
`timescale 1ns/1ps
module cpurf_addr_decode (
	input  wire logic [23:0]          addr,
	input  wire logic [23:0]          ram_size,
	input  wire logic [23:0]          rom_size,
	input  wire logic [127:0]         sfr_present,
	output cpurf_pkg::cpurf_decode_t  decode
);
	// ------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------
	// The fixed vectors and special page sit inside the ROM window, so
	// they are tested first and take priority over the plain ROM area.
	always_comb
	begin
		decode.reserved = 1'b0;
		if (addr >= cpurf_pkg::FIXVEC_FIRST)
			decode.region = cpurf_pkg::CPURF_REG_FIXVEC;
		else if (addr >= cpurf_pkg::SPAGE_FIRST &&
			addr <= cpurf_pkg::SPAGE_LAST)
			decode.region = cpurf_pkg::CPURF_REG_SPAGE;
		else if (addr >= 24'hFFFFFF - rom_size + 24'h000001)
			decode.region = cpurf_pkg::CPURF_REG_ROM;
		else if (addr <= cpurf_pkg::SFR_LAST)
		begin
			decode.region   = cpurf_pkg::CPURF_REG_SFR;
			// Each presence bit covers eight bytes of the area.
			decode.reserved = ~sfr_present[addr[9:3]];
		end
		else if (addr < cpurf_pkg::RAM_FIRST + ram_size)
			decode.region = cpurf_pkg::CPURF_REG_RAM;
		else
			decode.region = cpurf_pkg::CPURF_REG_EXT;
	end
endmodule

/* core/cpurf_top.sv */
// Processor register file, flag word and memory map decoder.
//
// Implementation choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
module cpurf_top (
	input  wire logic         clock,
	input  wire logic         rst,
	input  wire logic [7:0]   avs_address,
	input  wire logic         avs_read,
	input  wire logic         avs_write,
	input  wire logic [31:0]  avs_writedata,
	input  wire logic [3:0]   avs_byteenable,
	output logic      [31:0]  avs_readdata,
	output logic              avs_waitrequest,
	output logic [23:0]       active_stack_pointer,
	output logic [15:0]       processor_flag_word,
	output logic              interrupt_taken,
	output logic [2:0]        processor_priority_level
);
	// ------------------------------------------------------------------
	// Parameters of the memory sizes
	// ------------------------------------------------------------------
	localparam logic [23:0] RAM_SIZE = cpurf_pkg::RAM_SIZE_DEF;
	localparam logic [23:0] ROM_SIZE = cpurf_pkg::ROM_SIZE_DEF;
	// Every eight-byte slot of the peripheral area is present by default.
	localparam logic [127:0] SFR_PRESENT = {128{1'b1}};

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		cpurf_pkg::cpurf_bank_t [1:0] bank;
		logic [23:0] user_stack_pointer;
		logic [23:0] interrupt_stack_pointer;
		logic [23:0] vector_table_base;
		logic [23:0] next_instruction_pointer;
		logic [15:0] flag_word;
		logic        taken;
		logic        ack;
		logic [31:0] rdata;
		logic [31:0] alu_result;
		logic        alu_wide;
		logic [23:0] probe_addr;
	} cpurf_state_t;

	cpurf_state_t             st;
	cpurf_state_t             next_st;
	cpurf_pkg::cpurf_arith_t  arith;
	cpurf_pkg::cpurf_decode_t decode;
	logic [31:0]              wmask;
	logic                     sel_bank;
	logic                     wr;
	logic                     rd;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	// Byte enables widen to a bit mask so partial writes reach halves.
	assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign sel_bank = st.flag_word[cpurf_pkg::FLG_BANK];
	// A write lands at the edge that ends the wait state, where the
	// master samples waitrequest low. Reads fetch one edge earlier so the
	// registered data already stands at that edge.
	assign wr = avs_write & st.ack;
	assign rd = avs_read & ~st.ack;

	// One waitstate: the request is answered at the second edge after it rises.
	assign avs_waitrequest = (avs_read | avs_write) & ~st.ack;
	assign avs_readdata    = st.rdata;

	// ------------------------------------------------------------------
	// Submodules
	// ------------------------------------------------------------------
	cpurf_flag_eval u_flag_eval (
		.result   (avs_writedata),
		.wide     (avs_writedata[cpurf_pkg::ALU_WIDE]),
		.carry_in (avs_writedata[cpurf_pkg::ALU_CARRY]),
		.ovf_in   (avs_writedata[cpurf_pkg::ALU_OVF]),
		.flags    (arith)
	);

	cpurf_addr_decode u_addr_decode (
		.addr        (st.probe_addr),
		.ram_size    (RAM_SIZE),
		.rom_size    (ROM_SIZE),
		.sfr_present (SFR_PRESENT),
		.decode      (decode)
	);

	// ------------------------------------------------------------------
	// Merge of a 24-bit or 16-bit write under byte enables
	// ------------------------------------------------------------------
	function automatic logic [23:0] merge24(input logic [23:0] old,
		input logic [31:0] wd, input logic [31:0] m);
		merge24 = (old & ~m[23:0]) | (wd[23:0] & m[23:0]);
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] wd, input logic [31:0] m);
		merge16 = (old & ~m[15:0]) | (wd[15:0] & m[15:0]);
	endfunction

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	// Register writes, interrupt events and the read mux all live here
	// so a single flag word copy carries every update: an event is one
	// branch of the write decode and never meets another write in a cycle.
	always_comb
	begin
		logic [2:0]  lvl;
		logic [5:0]  num;
		logic [23:0] active_sp;
		next_st = st;
		lvl = avs_writedata[cpurf_pkg::EVT_LVL_HI:cpurf_pkg::EVT_LVL_LO];
		num = avs_writedata[cpurf_pkg::EVT_NUM_HI:cpurf_pkg::EVT_NUM_LO];
		active_sp = st.flag_word[cpurf_pkg::FLG_STACK] ?
			st.user_stack_pointer : st.interrupt_stack_pointer;
		next_st.ack   = (avs_read | avs_write) & ~st.ack;
		next_st.taken = 1'b0;
		// Only the selected bank is touched; the other keeps its values.
		if (wr)
		begin
			case (avs_address)
			cpurf_pkg::OFS_DATA_ZERO:
				next_st.bank[sel_bank].data_reg_zero = merge16(
					st.bank[sel_bank].data_reg_zero,
					avs_writedata, wmask);
			cpurf_pkg::OFS_DATA_ONE:
				next_st.bank[sel_bank].data_reg_one = merge16(
					st.bank[sel_bank].data_reg_one,
					avs_writedata, wmask);
			cpurf_pkg::OFS_DATA_TWO:
				next_st.bank[sel_bank].data_reg_two = merge16(
					st.bank[sel_bank].data_reg_two,
					avs_writedata, wmask);
			cpurf_pkg::OFS_DATA_THREE:
				next_st.bank[sel_bank].data_reg_three = merge16(
					st.bank[sel_bank].data_reg_three,
					avs_writedata, wmask);
			cpurf_pkg::OFS_LONG_LOW:
			begin
				next_st.bank[sel_bank].data_reg_zero = merge16(
					st.bank[sel_bank].data_reg_zero,
					avs_writedata, wmask);
				next_st.bank[sel_bank].data_reg_two = merge16(
					st.bank[sel_bank].data_reg_two,
					{16'h0000, avs_writedata[31:16]},
					{16'h0000, wmask[31:16]});
			end
			cpurf_pkg::OFS_LONG_HIGH:
			begin
				next_st.bank[sel_bank].data_reg_one = merge16(
					st.bank[sel_bank].data_reg_one,
					avs_writedata, wmask);
				next_st.bank[sel_bank].data_reg_three = merge16(
					st.bank[sel_bank].data_reg_three,
					{16'h0000, avs_writedata[31:16]},
					{16'h0000, wmask[31:16]});
			end
			cpurf_pkg::OFS_ADDR_ZERO:
				next_st.bank[sel_bank].addr_pointer_zero = merge24(
					st.bank[sel_bank].addr_pointer_zero,
					avs_writedata, wmask);
			cpurf_pkg::OFS_ADDR_ONE:
				next_st.bank[sel_bank].addr_pointer_one = merge24(
					st.bank[sel_bank].addr_pointer_one,
					avs_writedata, wmask);
			cpurf_pkg::OFS_STATIC_BASE:
				next_st.bank[sel_bank].static_base = merge24(
					st.bank[sel_bank].static_base,
					avs_writedata, wmask);
			cpurf_pkg::OFS_FRAME_BASE:
				next_st.bank[sel_bank].frame_base = merge24(
					st.bank[sel_bank].frame_base,
					avs_writedata, wmask);
			cpurf_pkg::OFS_USER_SP:
				next_st.user_stack_pointer = merge24(
					st.user_stack_pointer, avs_writedata, wmask);
			cpurf_pkg::OFS_INT_SP:
				next_st.interrupt_stack_pointer = merge24(
					st.interrupt_stack_pointer, avs_writedata, wmask);
			cpurf_pkg::OFS_ACTIVE_SP:
				if (st.flag_word[cpurf_pkg::FLG_STACK])
					next_st.user_stack_pointer = merge24(
						st.user_stack_pointer, avs_writedata, wmask);
				else
					next_st.interrupt_stack_pointer = merge24(
						st.interrupt_stack_pointer, avs_writedata,
						wmask);
			cpurf_pkg::OFS_VECTOR_BASE:
				next_st.vector_table_base = merge24(
					st.vector_table_base, avs_writedata, wmask);
			cpurf_pkg::OFS_NEXT_IP:
				next_st.next_instruction_pointer = merge24(
					st.next_instruction_pointer, avs_writedata, wmask);
			cpurf_pkg::OFS_FLAG_WORD:
				// Unimplemented bits are dropped and read as zero.
				next_st.flag_word = merge16(st.flag_word, avs_writedata,
					wmask) & cpurf_pkg::FLG_IMPL_MASK;
			cpurf_pkg::OFS_ALU_RESULT:
			begin
				next_st.alu_result = avs_writedata;
				if (avs_writedata[cpurf_pkg::ALU_UPDATE])
				begin
					next_st.flag_word[cpurf_pkg::FLG_CARRY] =
						arith.carry;
					next_st.flag_word[cpurf_pkg::FLG_ZERO] =
						arith.zero;
					next_st.flag_word[cpurf_pkg::FLG_SIGN] =
						arith.sign;
					next_st.flag_word[cpurf_pkg::FLG_OVERFLOW] =
						arith.overflow;
				end
			end
			cpurf_pkg::OFS_PROBE_ADDR:
				next_st.probe_addr = merge24(st.probe_addr,
					avs_writedata, wmask);
			cpurf_pkg::OFS_EVENT:
			begin
				// A hardware request is maskable and level-checked.
				if (avs_writedata[cpurf_pkg::EVT_HW_INT] &&
					st.flag_word[cpurf_pkg::FLG_INT_EN] &&
					lvl > st.flag_word[cpurf_pkg::FLG_IPL_HI:
					cpurf_pkg::FLG_IPL_LO])
				begin
					next_st.taken = 1'b1;
					next_st.flag_word[cpurf_pkg::FLG_INT_EN] = 1'b0;
					next_st.flag_word[cpurf_pkg::FLG_STACK] = 1'b0;
				end
				// A software interrupt is never masked.
				else if (avs_writedata[cpurf_pkg::EVT_SW_INT])
				begin
					next_st.taken = 1'b1;
					next_st.flag_word[cpurf_pkg::FLG_INT_EN] = 1'b0;
					if (num <= cpurf_pkg::SW_INT_STACK_MAX)
						next_st.flag_word[cpurf_pkg::FLG_STACK] =
							1'b0;
				end
			end
			default:
				next_st.rdata = st.rdata;
			endcase
		end
		// Read mux, registered so data stands with the answer.
		if (rd)
		begin
			case (avs_address)
			cpurf_pkg::OFS_DATA_ZERO:
				next_st.rdata = {16'h0000, st.bank[sel_bank].data_reg_zero};
			cpurf_pkg::OFS_DATA_ONE:
				next_st.rdata = {16'h0000, st.bank[sel_bank].data_reg_one};
			cpurf_pkg::OFS_DATA_TWO:
				next_st.rdata = {16'h0000, st.bank[sel_bank].data_reg_two};
			cpurf_pkg::OFS_DATA_THREE:
				next_st.rdata = {16'h0000,
					st.bank[sel_bank].data_reg_three};
			cpurf_pkg::OFS_LONG_LOW:
				next_st.rdata = {st.bank[sel_bank].data_reg_two,
					st.bank[sel_bank].data_reg_zero};
			cpurf_pkg::OFS_LONG_HIGH:
				next_st.rdata = {st.bank[sel_bank].data_reg_three,
					st.bank[sel_bank].data_reg_one};
			cpurf_pkg::OFS_ADDR_ZERO:
				next_st.rdata = {8'h00,
					st.bank[sel_bank].addr_pointer_zero};
			cpurf_pkg::OFS_ADDR_ONE:
				next_st.rdata = {8'h00,
					st.bank[sel_bank].addr_pointer_one};
			cpurf_pkg::OFS_STATIC_BASE:
				next_st.rdata = {8'h00, st.bank[sel_bank].static_base};
			cpurf_pkg::OFS_FRAME_BASE:
				next_st.rdata = {8'h00, st.bank[sel_bank].frame_base};
			cpurf_pkg::OFS_USER_SP:
				next_st.rdata = {8'h00, st.user_stack_pointer};
			cpurf_pkg::OFS_INT_SP:
				next_st.rdata = {8'h00, st.interrupt_stack_pointer};
			cpurf_pkg::OFS_ACTIVE_SP:
				next_st.rdata = {8'h00, active_sp};
			cpurf_pkg::OFS_VECTOR_BASE:
				next_st.rdata = {8'h00, st.vector_table_base};
			cpurf_pkg::OFS_NEXT_IP:
				next_st.rdata = {8'h00, st.next_instruction_pointer};
			cpurf_pkg::OFS_FLAG_WORD:
				next_st.rdata = {16'h0000, st.flag_word};
			cpurf_pkg::OFS_ALU_RESULT:
				next_st.rdata = st.alu_result;
			cpurf_pkg::OFS_PROBE_ADDR:
				next_st.rdata = {8'h00, st.probe_addr};
			cpurf_pkg::OFS_REGION:
				next_st.rdata = {28'h0000000, decode.reserved,
					decode.region};
			default:
				next_st.rdata = 32'h00000000;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			st <= '0;
			st.flag_word <= cpurf_pkg::FLG_RESET;
		end
		else
			st <= next_st;
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign active_stack_pointer = st.flag_word[cpurf_pkg::FLG_STACK] ?
		st.user_stack_pointer : st.interrupt_stack_pointer;
	assign processor_flag_word = st.flag_word;
	assign interrupt_taken = st.taken;
	assign processor_priority_level =
		st.flag_word[cpurf_pkg::FLG_IPL_HI:cpurf_pkg::FLG_IPL_LO];
endmodule

/* verif/cpurf_chk_sva.sv */
// Checker of flag word, handshake and event relations at the top ports.
`timescale 1ns/1ps
module cpurf_chk (
	input wire logic        clock,
	input wire logic        rst,
	input wire logic [7:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic [23:0] active_stack_pointer,
	input wire logic [15:0] processor_flag_word,
	input wire logic        interrupt_taken,
	input wire logic [2:0]  processor_priority_level
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	logic [15:0] f;
	logic [31:0] d;
	logic        wq;
	logic        ev;
	logic        al;
	// Full-word writes are taken at the edge that ends the wait state.
	assign f = processor_flag_word;
	assign d = avs_writedata;
	assign wq = avs_write && !avs_waitrequest && avs_byteenable == 4'hF;
	assign ev = wq && avs_address == cpurf_pkg::OFS_EVENT;
	assign al = wq && avs_address == cpurf_pkg::OFS_ALU_RESULT;
	wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("no answer after one wait");
	ipl_field_a: assert property (
		processor_priority_level == f[14:12]) else $error("level port");
	resv_zero_a: assert property (
		(f & ~cpurf_pkg::FLG_IMPL_MASK) == 16'h0000) else $error("resv");
	hw_block_a: assert property (
		ev && d[0] && !d[1] && (d[10:8] <= f[14:12] || !f[6])
		|=> $stable(f) && !interrupt_taken)
		else $error("blocked request changed flags");
	hw_take_a: assert property (
		ev && d[0] && d[10:8] > f[14:12] && f[6]
		|=> !f[6] && !f[7] && interrupt_taken)
		else $error("accepted request kept flags");
	sw_stack_a: assert property (
		ev && !d[0] && d[1] |=> !f[6] && interrupt_taken
		&& f[7] == ($past(f[7]) && $past(d[21:16]) > 6'h1F))
		else $error("software interrupt flags");
	bank_shared_a: assert property (
		wq && avs_address == cpurf_pkg::OFS_FLAG_WORD && d[7] == f[7]
		|=> $stable(active_stack_pointer)) else $error("sp moved");
	alu_cv_a: assert property (al && d[18] |=>
		f[0] == $past(d[16]) && f[5] == $past(d[17])) else $error("c/v");
	alu_zs_a: assert property (al && d[18] |=>
		f[2] == ($past(d[19]) ? $past(d) == 32'h0 : $past(d[15:0]) == 16'h0)
		&& f[3] == ($past(d[19]) ? $past(d[31]) : $past(d[15])))
		else $error("zero or sign flag");
	taken_pulse_a: assert property (
		interrupt_taken |=> !interrupt_taken) else $error("long pulse");
endmodule

/* verif/cpurf_top_tb.sv */
// Register-bus bench for the processor register file.
`timescale 1ns/1ps
module cpurf_top_tb;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  avs_address = 8'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'hF;
	logic [31:0] avs_readdata, got;
	logic        avs_waitrequest, interrupt_taken;
	logic [23:0] active_stack_pointer;
	logic [15:0] processor_flag_word;
	logic [2:0]  processor_priority_level;
	int          failures = 0;
	int          n_compared = 0;
	int          i;
	logic [31:0] pa [10] = '{32'h0, 32'h3FF, 32'h400, 32'h83FF, 32'h8400,
		32'hFC0000, 32'hFFFE00, 32'hFFFFDB, 32'hFFFFDC, 32'hFFFFFF};
	logic [31:0] pr [10] = '{32'h0, 32'h0, 32'h1, 32'h1, 32'h2, 32'h3, 32'h4,
		32'h4, 32'h5, 32'h5};
	logic [31:0] av [4] = '{32'h40000, 32'h78000, 32'hC0000, 32'h800D0000};
	logic [31:0] af [4] = '{32'h4, 32'h29, 32'h0, 32'h9};
	cpurf_top dut (.clock(clock), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.active_stack_pointer(active_stack_pointer),
		.processor_flag_word(processor_flag_word),
		.interrupt_taken(interrupt_taken),
		.processor_priority_level(processor_priority_level));
	// Core clock at 100 MHz.
	initial forever #5 clock = ~clock;
	task complete_run;
		if (failures == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task check(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e)
		begin
			failures++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask
	// One access: the request stands until waitrequest is seen low at a
	// rising edge, and read data is taken at that same edge.
	task acc(input logic r, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] be);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_read <= r;
		avs_write <= !r;
		@(posedge clock);
		while (avs_waitrequest !== 1'b0) @(posedge clock);
		got = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clock);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		acc(1'b0, a, d, 4'hF);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		acc(1'b1, a, 32'h0, 4'hF);
		check(got, e);
	endtask
	initial
	begin
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		for (i = 0; i < 16; i++) rd(8'(4 * i), 32'h0);
		rd(8'h50, 32'h0);
		for (i = 0; i < 12; i++)
		begin
			wr(8'(4 * i), 32'hFFFFFFFF);
			rd(8'(4 * i), i < 4 ? 32'hFFFF : 32'hFFFFFF);
		end
		wr(8'h00, 32'h1234);
		acc(1'b0, 8'h00, 32'hAB00, 4'h2);
		rd(8'h00, 32'hAB34);
		wr(8'h08, 32'h2222);
		rd(8'h34, 32'h2222AB34);
		wr(8'h38, 32'hAAAA5555);
		rd(8'h04, 32'h5555);
		rd(8'h0C, 32'hAAAA);
		wr(8'h30, 32'h10);
		wr(8'h00, 32'h7777);
		rd(8'h00, 32'h7777);
		wr(8'h30, 32'h0);
		rd(8'h00, 32'hAB34);
		wr(8'h20, 32'h111111);
		wr(8'h24, 32'h222222);
		rd(8'h3C, 32'h222222);
		wr(8'h30, 32'h90);
		rd(8'h3C, 32'h111111);
		check({8'h00, active_stack_pointer}, 32'h111111);
		wr(8'h30, 32'h30C0);
		wr(8'h40, 32'h301);
		rd(8'h30, 32'h30C0);
		wr(8'h40, 32'h401);
		rd(8'h30, 32'h3000);
		wr(8'h30, 32'h3080);
		wr(8'h40, 32'h701);
		rd(8'h30, 32'h3080);
		wr(8'h30, 32'hC0);
		wr(8'h40, 32'h1F0002);
		rd(8'h30, 32'h0);
		wr(8'h30, 32'hC0);
		wr(8'h40, 32'h200002);
		rd(8'h30, 32'h80);
		wr(8'h30, 32'h0);
		for (i = 0; i < 4; i++)
		begin
			wr(8'h44, av[i]);
			rd(8'h30, af[i]);
		end
		wr(8'h30, 32'h70FD);
		rd(8'h30, 32'h70FD);
		for (i = 0; i < 10; i++)
		begin
			wr(8'h48, pa[i]);
			rd(8'h4C, pr[i]);
		end
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		rd(8'h30, 32'h0);
		rd(8'h20, 32'h0);
		complete_run;
	end
	// A hung handshake ends the run as a mismatch.
	initial
	begin
		repeat (20000) @(posedge clock);
		failures++;
		complete_run;
	end
endmodule
bind cpurf_top cpurf_chk chk (.clock(clock), .rst(rst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.active_stack_pointer(active_stack_pointer),
	.processor_flag_word(processor_flag_word),
	.interrupt_taken(interrupt_taken),
	.processor_priority_level(processor_priority_level));
